// >>> core/rpc_pkg.sv
// Purpose: Shared constants and types for the reset and power-down sequencer
// Assumes: 10 MHz core clock, 32-bit AHB-Lite register bus
// Notes:   Times are given in their own unit and turned into cycle counts here
package rpc_pkg;
    // Core clock
    localparam int unsigned CORE_CLK_HZ       = 10_000_000;
    localparam int unsigned CYCLES_PER_MS     = CORE_CLK_HZ / 1000;
    // Reset period and isolated-side start-up
    localparam int unsigned RESET_PERIOD_MS   = 20;
    localparam int unsigned RESET_CYCLES      = RESET_PERIOD_MS * CYCLES_PER_MS;
    localparam int unsigned ISO_START_MS      = 100;
    localparam int unsigned ISO_START_CYCLES  = ISO_START_MS * CYCLES_PER_MS;
    localparam int unsigned SOFT_RESET_CYCLES = 16;
    // Serial hard-reset detection
    localparam int unsigned HARD_RESET_SCLKS  = 64;
    localparam int unsigned HARD_CNT_W        = 6;
    // Clock output half period in core cycles
    localparam int unsigned CLKOUT_HALF       = 2;
    localparam int unsigned SEQ_CNT_W         = 21;

    // Register byte offsets
    localparam logic [7:0] ADDR_SETUP         = 8'h00;
    localparam logic [7:0] ADDR_PRIMARY_STAT  = 8'h04;
    localparam logic [7:0] ADDR_SECONDARY_STAT= 8'h08;
    localparam logic [7:0] ADDR_LOCK          = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK      = 8'h14;

    // Setup register fields and reset value
    localparam int unsigned SETUP_CLKOUT_BIT  = 0;
    localparam int unsigned SETUP_PWRDN_BIT   = 2;
    localparam int unsigned SETUP_SOFTRST_BIT = 6;
    localparam logic [7:0] SETUP_RESET        = 8'h00;
    // Primary status field
    localparam int unsigned PRI_PENDING_BIT   = 0;
    // Lock keys
    localparam logic [7:0] LOCK_KEY           = 8'hCA;
    localparam logic [7:0] UNLOCK_KEY         = 8'h9C;
    // Interrupt status bits
    localparam int unsigned IRQ_W             = 3;
    localparam int unsigned IRQ_HARD_BIT      = 0;
    localparam int unsigned IRQ_DONE_BIT      = 1;
    localparam int unsigned IRQ_SOFT_BIT      = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    // Register index used by the decoder
    typedef enum logic [2:0] {
        REG_SETUP  = 3'b000,
        REG_PRI    = 3'b001,
        REG_SEC    = 3'b010,
        REG_LOCK   = 3'b011,
        REG_IRQS   = 3'b100,
        REG_IRQM   = 3'b101,
        REG_NONE   = 3'b111
    } reg_index_type;

    // Reset sequencer states
    typedef enum logic [1:0] {
        ST_HARD  = 2'b00,
        ST_SOFT  = 2'b01,
        ST_READY = 2'b10
    } seq_state_type;
endpackage : rpc_pkg

// >>> core/pin_sync.sv
// Purpose: Two-flop synchroniser for pins from outside the core clock domain
// Assumes: Pins change slowly against the core clock
// Notes:   Only the second stage is visible to the rest of the design
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned W   = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_rst,
    // Pins
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_q <= INIT;
            o_sync <= INIT;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : pin_sync
`default_nettype wire

// >>> core/reset_powerdown_control.sv
// Purpose: Reset, power-down and start-up sequencing with AHB-Lite registers
// Assumes: Serial pins are asynchronous; the serial clock is sampled by i_core_clk
// Notes:   Register offsets and interrupt layout live in rpc_pkg
//
// Contract
// - Hard reset restores setup, lock and pending to defaults and stops the converter; interrupt mask keeps its value, status keeps its bits and sets bit 0.
// - End of reset period clears the reset-pending flag, status bit 0.
// - Writing 1 to setup bit 6 starts a software reset to defaults.
// - Software reset keeps the isolated converter running.
// - Software reset end clears bit 6 and the reset-pending flag.
// - Power-down bit 2 stops converter and modulators; samples become invalid.
// - Power-down bit clear keeps converter and modulators running outside the hard reset period.
// - Clock-output enable bit 0 clear: no clock driven on the pin.
// - Secondary status bits 2:0 report the silicon version, read-only.
// - Isolated side ready about 100 ms after converter starts.
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module reset_powerdown_control
    import rpc_pkg::*;
#(
    parameter int unsigned  P_RESET_CYCLES = RESET_CYCLES,
    parameter int unsigned  P_ISO_CYCLES   = ISO_START_CYCLES,
    // Arbitrary value
    parameter logic [2:0]   P_VERSION      = 3'h1
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic             o_hreadyout,
    output logic             o_hresp,
    output logic [31:0]      o_hrdata,
    // Serial link pins
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_mosi,
    // Power and status
    output logic             o_dcdc_en,
    output logic             o_modulator_en,
    output logic             o_iso_ready,
    output logic             o_samples_valid,
    output logic             o_clock_or_ready_pin,
    output logic             o_irq
);
    function automatic reg_index_type decode(input logic [31:0] addr);
        case (addr[7:0])
            ADDR_SETUP:          decode = REG_SETUP;
            ADDR_PRIMARY_STAT:   decode = REG_PRI;
            ADDR_SECONDARY_STAT: decode = REG_SEC;
            ADDR_LOCK:           decode = REG_LOCK;
            ADDR_IRQ_STATUS:     decode = REG_IRQS;
            ADDR_IRQ_MASK:       decode = REG_IRQM;
            default:             decode = REG_NONE;
        endcase
        if (addr[31:8] != 24'h00_0000)
            decode = REG_NONE;
    endfunction : decode

    localparam logic [HARD_CNT_W-1:0] HARD_LAST = HARD_CNT_W'(HARD_RESET_SCLKS - 1);
    localparam logic [SEQ_CNT_W-1:0]  HARD_END  = SEQ_CNT_W'(P_RESET_CYCLES - 1);
    localparam logic [SEQ_CNT_W-1:0]  SOFT_END  = SEQ_CNT_W'(SOFT_RESET_CYCLES - 1);
    localparam logic [SEQ_CNT_W-1:0]  ISO_END   = SEQ_CNT_W'(P_ISO_CYCLES - 1);
    localparam logic [SEQ_CNT_W-1:0]  CLK_END   = SEQ_CNT_W'(CLKOUT_HALF - 1);

    logic [2:0]            pins_s;
    logic                  sclk_s;
    logic                  cs_n_s;
    logic                  mosi_s;
    logic                  sclk_prev_q;
    logic                  sclk_rise;
    logic [HARD_CNT_W-1:0] hard_cnt_q;
    logic                  hard_hit;
    seq_state_type         state_q;
    logic [SEQ_CNT_W-1:0]  seq_cnt_q;
    logic                  seq_end;
    logic [SEQ_CNT_W-1:0]  iso_cnt_q;
    logic [SEQ_CNT_W-1:0]  clk_cnt_q;
    logic                  clk_tog_q;
    logic [7:0]            setup_q;
    logic                  pending_q;
    logic                  locked_q;
    logic [IRQ_W-1:0]      irq_stat_q;
    logic [IRQ_W-1:0]      irq_mask_q;
    logic [IRQ_W-1:0]      irq_set;
    logic                  wr_pend_q;
    reg_index_type         wr_idx_q;
    logic                  addr_ok;
    logic                  wr_ok;
    logic                  soft_go;
    logic [7:0]            wdat;

    pin_sync #(
        .W    (3),
        .INIT (3'b110)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    ({i_cs_n, i_mosi, i_sclk}),
        .o_sync     (pins_s)
    );

    assign cs_n_s    = pins_s[2];
    assign mosi_s    = pins_s[1];
    assign sclk_s    = pins_s[0];
    assign sclk_rise = sclk_s && !sclk_prev_q;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            sclk_prev_q <= 1'b0;
        else
            sclk_prev_q <= sclk_s;
    end

    assign hard_hit = sclk_rise && !cs_n_s && !mosi_s && (hard_cnt_q == HARD_LAST);

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            hard_cnt_q <= '0;
        else if (cs_n_s || mosi_s || hard_hit)
            hard_cnt_q <= '0;
        else if (sclk_rise)
            hard_cnt_q <= hard_cnt_q + 1'b1;
    end

    // Bus handshake
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign addr_ok     = i_hsel && i_hready && i_htrans[1];
    assign wdat        = i_hwdata[7:0];
    assign wr_ok       = wr_pend_q && (state_q == ST_READY) && !hard_hit;
    assign soft_go     = wr_ok && (wr_idx_q == REG_SETUP) && !locked_q && wdat[SETUP_SOFTRST_BIT];

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= REG_NONE;
        end
        else
        begin
            wr_pend_q <= addr_ok && i_hwrite;
            wr_idx_q  <= decode(i_haddr);
        end
    end

    assign seq_end = (state_q == ST_HARD) ? (seq_cnt_q == HARD_END) : (seq_cnt_q == SOFT_END);

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q   <= ST_HARD;
            seq_cnt_q <= '0;
        end
        else if (hard_hit)
        begin
            state_q   <= ST_HARD;
            seq_cnt_q <= '0;
        end
        else
        begin
            case (state_q)
                ST_HARD, ST_SOFT:
                begin
                    seq_cnt_q <= seq_cnt_q + 1'b1;
                    if (seq_end)
                        state_q <= ST_READY;
                end
                ST_READY:
                begin
                    seq_cnt_q <= '0;
                    if (soft_go)
                        state_q <= ST_SOFT;
                end
                default:
                begin
                    state_q   <= ST_HARD;
                    seq_cnt_q <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            pending_q <= 1'b1;
        else if (hard_hit || soft_go)
            pending_q <= 1'b1;
        else if (state_q != ST_READY && seq_end)
            pending_q <= 1'b0;
    end

    // Setup register with self-clearing soft reset
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            setup_q <= SETUP_RESET;
        else if (hard_hit)
            setup_q <= SETUP_RESET;
        else if (soft_go)
            setup_q <= SETUP_RESET | (8'h01 << SETUP_SOFTRST_BIT);
        else if (state_q == ST_SOFT && seq_end)
            setup_q <= SETUP_RESET;
        else if (wr_ok && wr_idx_q == REG_SETUP && !locked_q)
            setup_q <= wdat;
    end

    // Lock keys
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            locked_q <= 1'b0;
        else if (hard_hit || soft_go)
            locked_q <= 1'b0;
        else if (wr_ok && wr_idx_q == REG_LOCK && wdat == LOCK_KEY)
            locked_q <= 1'b1;
        else if (wr_ok && wr_idx_q == REG_LOCK && wdat == UNLOCK_KEY)
            locked_q <= 1'b0;
    end

    assign o_dcdc_en       = (state_q != ST_HARD) && !setup_q[SETUP_PWRDN_BIT];
    assign o_modulator_en  = o_dcdc_en;
    assign o_iso_ready     = o_dcdc_en && (iso_cnt_q == ISO_END);
    assign o_samples_valid = o_iso_ready && (state_q == ST_READY);

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            iso_cnt_q <= '0;
        else if (!o_dcdc_en)
            iso_cnt_q <= '0;
        else if (iso_cnt_q != ISO_END)
            iso_cnt_q <= iso_cnt_q + 1'b1;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            clk_cnt_q            <= '0;
            clk_tog_q            <= 1'b0;
            o_clock_or_ready_pin <= 1'b1;
        end
        else if (!setup_q[SETUP_CLKOUT_BIT])
        begin
            clk_cnt_q            <= '0;
            clk_tog_q            <= 1'b0;
            o_clock_or_ready_pin <= 1'b1;
        end
        else
        begin
            clk_cnt_q            <= (clk_cnt_q == CLK_END) ? '0 : clk_cnt_q + 1'b1;
            clk_tog_q            <= (clk_cnt_q == CLK_END) ? !clk_tog_q : clk_tog_q;
            o_clock_or_ready_pin <= clk_tog_q;
        end
    end

    // Interrupt status, set wins over clear
    assign irq_set = {soft_go, (state_q != ST_READY) && seq_end && !hard_hit, hard_hit};

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            irq_stat_q <= '0;
        else if (wr_pend_q && wr_idx_q == REG_IRQS)
            irq_stat_q <= (irq_stat_q & ~i_hwdata[IRQ_W-1:0]) | irq_set;
        else
            irq_stat_q <= irq_stat_q | irq_set;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            irq_mask_q <= IRQ_MASK_RESET;
        else if (wr_pend_q && wr_idx_q == REG_IRQM)
            irq_mask_q <= i_hwdata[IRQ_W-1:0];
    end

    assign o_irq = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            o_hrdata <= 32'h0000_0000;
        else if (addr_ok && !i_hwrite)
        begin
            case (decode(i_haddr))
                REG_SETUP: o_hrdata <= {24'h00_0000, setup_q};
                REG_PRI:   o_hrdata <= {31'h0000_0000, pending_q};
                REG_SEC:   o_hrdata <= {29'h0000_0000, P_VERSION};
                REG_LOCK:  o_hrdata <= {31'h0000_0000, locked_q};
                REG_IRQS:  o_hrdata <= {29'h0000_0000, irq_stat_q};
                REG_IRQM:  o_hrdata <= {29'h0000_0000, irq_mask_q};
                default:   o_hrdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_soft_tail;
        (state_q == ST_SOFT) && seq_end && !hard_hit;
    endsequence

    sequence s_soft_done;
        !setup_q[SETUP_SOFTRST_BIT] && !pending_q && (state_q == ST_READY);
    endsequence

    property p_hard_trigger;
        hard_hit |=> (state_q == ST_HARD) && pending_q && (seq_cnt_q == '0);
    endproperty
    a_hard_trigger: assert property (p_hard_trigger) else $error("hard reset not entered");

    property p_count_restart;
        (cs_n_s || mosi_s) |=> (hard_cnt_q == '0);
    endproperty
    a_count_restart: assert property (p_count_restart) else $error("count not restarted");

    property p_hard_defaults;
        hard_hit |=> (setup_q == SETUP_RESET) && !o_dcdc_en && !locked_q;
    endproperty
    a_hard_defaults: assert property (p_hard_defaults) else $error("hard reset defaults");

    property p_hard_done;
        ((state_q == ST_HARD) && seq_end && !hard_hit) |=> !pending_q && (state_q == ST_READY);
    endproperty
    a_hard_done: assert property (p_hard_done) else $error("pending not cleared");

    property p_soft_start;
        soft_go |=> (state_q == ST_SOFT) && setup_q[SETUP_SOFTRST_BIT] && pending_q;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("soft reset not started");

    property p_soft_keeps_dcdc;
        (state_q == ST_SOFT) |-> o_dcdc_en;
    endproperty
    a_soft_keeps_dcdc: assert property (p_soft_keeps_dcdc) else $error("converter stopped");

    property p_soft_end;
        s_soft_tail |=> s_soft_done;
    endproperty
    a_soft_end: assert property (p_soft_end) else $error("soft reset end wrong");

    property p_power_down;
        setup_q[SETUP_PWRDN_BIT] |-> !o_dcdc_en && !o_modulator_en && !o_samples_valid;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down not honoured");

    property p_power_up;
        ((state_q == ST_READY) && !setup_q[SETUP_PWRDN_BIT]) |-> o_dcdc_en && o_modulator_en;
    endproperty
    a_power_up: assert property (p_power_up) else $error("converter not running");

    property p_no_clock;
        !setup_q[SETUP_CLKOUT_BIT] |=> o_clock_or_ready_pin;
    endproperty
    a_no_clock: assert property (p_no_clock) else $error("clock driven while off");

    property p_version;
        (addr_ok && !i_hwrite && decode(i_haddr) == REG_SEC) |=> (o_hrdata == {29'h0000_0000, P_VERSION});
    endproperty
    a_version: assert property (p_version) else $error("version read wrong");

    property p_iso_start;
        !o_dcdc_en |=> !o_iso_ready;
    endproperty
    a_iso_start: assert property (p_iso_start) else $error("iso ready too early");
endmodule : reset_powerdown_control
`default_nettype wire

// >>> dv/serial_host_model.sv
// Purpose: Host model driving the serial link pins
// Assumes: 800 ns serial clock, idle clock low
// Notes:   Clock stands still between frames; data inverts when released
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    // Link pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi
);
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b1;
    end
    // zero frame, one set bit at brk
    task automatic frame(input int n, input int brk);
        o_cs_n <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            o_mosi <= (i == brk);
            #400 o_sclk <= 1'b1;
            #400 o_sclk <= 1'b0;
        end
        o_cs_n <= 1'b1;
        o_mosi <= ~o_mosi;
    endtask : frame
endmodule : serial_host_model
`default_nettype wire

// >>> dv/tb_reset_powerdown_control.sv
// Purpose: Self-checking bench for the reset and power-down sequencer
// Assumes: Short reset and start-up counts set by parameter
// Notes:   Serial frames come from the host model
`timescale 1ns/1ps
`default_nettype none
module tb_reset_powerdown_control;
    import rpc_pkg::*;
    localparam int unsigned RST_CYC = 50;
    localparam int unsigned ISO_CYC = 80;
    // Arbitrary version value
    localparam logic [2:0]  VER     = 3'h5;
    logic        clk = 1'b0;
    logic        rst, hsel, hwrite, hreadyout, hresp, sclk, cs_n, mosi;
    logic        dcdc, modl, isor, svalid, ckpin, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          n_fail = 0;
    int          n_checks = 0;

    always #50 clk = ~clk;

    reset_powerdown_control #(
        .P_RESET_CYCLES (RST_CYC),
        .P_ISO_CYCLES   (ISO_CYC),
        .P_VERSION      (VER)
    ) reset_powerdown_control_inst (
        .i_core_clk           (clk),
        .i_rst                (rst),
        .i_hsel               (hsel),
        .i_haddr              (haddr),
        .i_htrans             (htrans),
        .i_hwrite             (hwrite),
        .i_hsize              (hsize),
        .i_hwdata             (hwdata),
        .i_hready             (hreadyout),
        .o_hreadyout          (hreadyout),
        .o_hresp              (hresp),
        .o_hrdata             (hrdata),
        .i_sclk               (sclk),
        .i_cs_n               (cs_n),
        .i_mosi               (mosi),
        .o_dcdc_en            (dcdc),
        .o_modulator_en       (modl),
        .o_iso_ready          (isor),
        .o_samples_valid      (svalid),
        .o_clock_or_ready_pin (ckpin),
        .o_irq                (irq)
    );

    serial_host_model serial_host_model_inst (
        .o_sclk (sclk),
        .o_cs_n (cs_n),
        .o_mosi (mosi)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic timeout();
        n_fail++;
        $display("unexpected wait: expected done seen timeout");
        summarize();
    endtask : timeout

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask : waitc

    task automatic wait_rdy();
        @(posedge clk);
        for (int k = 0; k < 20 && hreadyout !== 1'b1; k++)
            @(posedge clk);
        if (hreadyout !== 1'b1)
            timeout();
    endtask : wait_rdy

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= 32'(a);
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        check("hresp", 32'(hresp), 32'h0000_0000);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        check(nm, q, e);
    endtask : rd

    task automatic poll();
        logic [31:0] q;
        q = 32'h0000_0001;
        for (int k = 0; k < 100 && q[0] !== 1'b0; k++)
            xfer(1'b0, ADDR_PRIMARY_STAT, 32'h0000_0000, q);
        if (q[0] !== 1'b0)
            timeout();
    endtask : poll

    task automatic edges(input string nm, input int e);
        int n;
        logic p;
        n = 0;
        waitc(4);
        p = ckpin;
        repeat (16)
        begin
            @(posedge clk);
            if (ckpin !== p)
                n++;
            p = ckpin;
        end
        check(nm, 32'(n), 32'(e));
    endtask : edges

    task automatic t_powerup();
        rd("pending", ADDR_PRIMARY_STAT, 32'h0000_0001);
        check("dcdc off", 32'(dcdc), 32'h0000_0000);
        rd("setup", ADDR_SETUP, 32'h0000_0000);
        wr(ADDR_SECONDARY_STAT, 32'h0000_0000);
        rd("version", ADDR_SECONDARY_STAT, 32'(VER));
        poll();
        check("dcdc on", 32'(dcdc), 32'h0000_0001);
        check("mod on", 32'(modl), 32'h0000_0001);
        check("iso early", 32'(isor), 32'h0000_0000);
        waitc(ISO_CYC - 10);
        check("iso wait", 32'(isor), 32'h0000_0000);
        waitc(15);
        check("iso ready", 32'(isor), 32'h0000_0001);
        check("valid", 32'(svalid), 32'h0000_0001);
    endtask : t_powerup

    task automatic t_powerdown();
        wr(ADDR_SETUP, 32'h0000_0004);
        waitc(2);
        check("pd dcdc", 32'(dcdc), 32'h0000_0000);
        check("pd mod", 32'(modl), 32'h0000_0000);
        check("pd valid", 32'(svalid), 32'h0000_0000);
        rd("pd setup", ADDR_SETUP, 32'h0000_0004);
        wr(ADDR_SETUP, 32'h0000_0000);
        waitc(2);
        check("up dcdc", 32'(dcdc), 32'h0000_0001);
        check("up mod", 32'(modl), 32'h0000_0001);
    endtask : t_powerdown

    task automatic t_clkout();
        wr(ADDR_SETUP, 32'h0000_0001);
        edges("clk on", 16 / CLKOUT_HALF);
        wr(ADDR_SETUP, 32'h0000_0000);
        edges("clk off", 0);
        check("pin idle", 32'(ckpin), 32'h0000_0001);
    endtask : t_clkout

    task automatic t_soft();
        wr(ADDR_LOCK, 32'h0000_00CA);
        rd("locked", ADDR_LOCK, 32'h0000_0001);
        wr(ADDR_SETUP, 32'h0000_0040);
        rd("lock refuses", ADDR_SETUP, 32'h0000_0000);
        wr(ADDR_LOCK, 32'h0000_009C);
        wr(ADDR_SETUP, 32'h0000_0040);
        rd("soft pend", ADDR_PRIMARY_STAT, 32'h0000_0001);
        rd("soft bit", ADDR_SETUP, 32'h0000_0040);
        check("soft dcdc", 32'(dcdc), 32'h0000_0001);
        poll();
        rd("soft end", ADDR_SETUP, 32'h0000_0000);
        check("soft dcdc end", 32'(dcdc), 32'h0000_0001);
    endtask : t_soft

    task automatic t_hard();
        wr(ADDR_SETUP, 32'h0000_0001);
        wr(ADDR_LOCK, 32'h0000_00CA);
        serial_host_model_inst.frame(127, 63);
        waitc(6);
        rd("no trigger", ADDR_PRIMARY_STAT, 32'h0000_0000);
        rd("setup kept", ADDR_SETUP, 32'h0000_0001);
        serial_host_model_inst.frame(64, -1);
        waitc(6);
        check("hard dcdc", 32'(dcdc), 32'h0000_0000);
        rd("hard pend", ADDR_PRIMARY_STAT, 32'h0000_0001);
        poll();
        rd("hard setup", ADDR_SETUP, 32'h0000_0000);
        rd("hard lock", ADDR_LOCK, 32'h0000_0000);
    endtask : t_hard

    task automatic t_irq();
        rd("irq status", ADDR_IRQ_STATUS, 32'h0000_0007);
        check("irq masked", 32'(irq), 32'h0000_0000);
        wr(ADDR_IRQ_MASK, 32'h0000_0002);
        waitc(2);
        check("irq on", 32'(irq), 32'h0000_0001);
        wr(ADDR_IRQ_STATUS, 32'h0000_0002);
        waitc(2);
        check("irq cleared", 32'(irq), 32'h0000_0000);
        rd("irq left", ADDR_IRQ_STATUS, 32'h0000_0005);
        wr(8'h18, 32'h0000_00FF);
        rd("unmapped", 8'h18, 32'h0000_0000);
    endtask : t_irq

    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_powerup();
        t_powerdown();
        t_clkout();
        t_soft();
        t_hard();
        t_irq();
        summarize();
    end
endmodule : tb_reset_powerdown_control
`default_nettype wire
